// file: design/plt_logic_array.sv
`timescale 1ns/1ps
module plt_logic_array (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [plt_pkg::PLA_IN-1:0] in_i,
    input wire plt_pkg::plt_pla_cfg_t cfg_i,
    output logic [plt_pkg::PLA_OUTS-1:0] out_o
);
    typedef struct packed {
        logic [plt_pkg::PLA_OUTS-1:0] q;
    } plt_la_state_t;

    plt_la_state_t s_reg;
    plt_la_state_t s_next;
    logic [plt_pkg::PLA_TERMS-1:0] term;
    logic [plt_pkg::PLA_OUTS-1:0] sum;

    always_comb begin
        for (int t = 0; t < plt_pkg::PLA_TERMS; t++) begin
            // An unselected input leaves the term unaffected.
            term[t] = &(~(cfg_i.and_true[t] & ~in_i) & ~(cfg_i.and_comp[t] & in_i));
        end
        for (int o = 0; o < plt_pkg::PLA_OUTS; o++) begin
            sum[o] = |(term & cfg_i.or_sel[o]);
        end
        s_next.q = sum;
        out_o = (cfg_i.reg_out & s_reg.q) | (~cfg_i.reg_out & sum);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // plt_logic_array

// file: design/plt_pkg.sv
// How it works
// - Each logic array takes twelve routed inputs spread over eight product terms.
// - A product term ANDs one to twelve inputs, each taken true or inverted.
// - Each logic array output ORs one to eight product terms.
// - Every logic array output has the same fixed eight-term OR width.
// - The tile holds exactly two twelve-input logic arrays.
// - Each logic array output is selectable as registered or combinational.
// - The datapath works on 8-bit operands, one operation per clock.
// - Accumulators feed the ALU and compares and take ALU results.
// - Data registers feed the ALU and compares, never written by ALU.
// - Two four-byte queues load working registers or capture accumulators or ALU.
// - Eight 16-bit configuration words each define a full datapath function.
// - Routed inputs address the configuration memory, changeable every cycle.
// - ALU offers increment, decrement, add, subtract, AND, OR, XOR, pass.
// - Shift left, shift right, nibble swap or OR mask follow the ALU.
// - Two masked comparators with selectable accumulator and data register pairings.
// - Zero, all-ones and overflow detect; selected conditions drive routing outputs.
// - Programmable MSB position for arithmetic and shift, with output masking.
// - One CRC or pseudo-random step per clock, programmable polynomial and width.
// - Each queue is set independently as bus-to-datapath or datapath-to-bus.
// - Queue status is selectable as datapath outputs.
// - Carry, shift data and compare chain directly to neighbouring tiles.
// - Carry out and shift out are registered for use in later cycles.
// - Six routing inputs and six routing outputs connect the datapath.
package plt_pkg;
    localparam int DATA_W = 8;
    localparam int QUEUE_DEPTH = 4;
    localparam int CFG_WORDS = 8;
    localparam int CFG_W = 16;
    localparam int PLA_IN = 12;
    localparam int PLA_TERMS = 8;
    localparam int PLA_OUTS = 4;
    localparam int PLA_COUNT = 2;
    localparam int ROUTE_W = 6;
    localparam int ADDR_W = 5;
    localparam int COND_N = 16;

    localparam logic [4:0] ADDR_ACC0 = 5'h00;
    localparam logic [4:0] ADDR_ACC1 = 5'h01;
    localparam logic [4:0] ADDR_DAT0 = 5'h02;
    localparam logic [4:0] ADDR_DAT1 = 5'h03;
    localparam logic [4:0] ADDR_QUEUE0 = 5'h04;
    localparam logic [4:0] ADDR_QUEUE1 = 5'h05;
    localparam logic [4:0] ADDR_CMP_MASK0 = 5'h06;
    localparam logic [4:0] ADDR_CMP_MASK1 = 5'h07;
    localparam logic [4:0] ADDR_OR_MASK = 5'h08;
    localparam logic [4:0] ADDR_POLY = 5'h09;
    localparam logic [4:0] ADDR_CTRL = 5'h0A;
    localparam logic [4:0] ADDR_STATUS = 5'h0B;
    localparam logic [4:0] ADDR_OSEL0 = 5'h0C;
    localparam logic [4:0] ADDR_OSEL1 = 5'h0D;
    localparam logic [4:0] ADDR_OSEL2 = 5'h0E;
    localparam logic [4:0] ADDR_CTRL2 = 5'h0F;
    localparam int CFG_SPACE_BIT = 4;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hFF;
    localparam logic [7:0] RST_CTRL = 8'h07;

    localparam int CTRL_MSB_LSB = 0;
    localparam int CTRL_Q0_OUT = 3;
    localparam int CTRL_Q1_OUT = 4;
    localparam int CTRL_SIN_LSB = 5;
    localparam int CTRL_CHAIN_CMP = 7;
    localparam int CTRL2_Q0_TGT_LSB = 0;
    localparam int CTRL2_Q1_TGT_LSB = 2;
    localparam int CTRL2_CAP_LSB = 4;
    localparam int CTRL2_CMP0_PAIR = 6;
    localparam int CTRL2_CMP1_PAIR = 7;

    localparam int ROUTE_ADDR_LSB = 0;
    localparam int ROUTE_SIN = 3;
    localparam int ROUTE_CIN = 4;
    localparam int ROUTE_RUN = 5;

    typedef enum logic [2:0] {
        FN_PASS, FN_INC, FN_DEC, FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR
    } plt_func_t;

    typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} plt_shift_t;

    typedef struct packed {
        logic q1_xfer;
        logic q0_xfer;
        logic crc_en;
        logic cin_reg;
        logic [1:0] dest;
        logic or_mask_en;
        plt_shift_t shift;
        logic [1:0] src_b;
        logic [1:0] src_a;
        plt_func_t func;
    } plt_cfg_word_t;

    typedef struct packed {
        logic [PLA_TERMS-1:0][PLA_IN-1:0] and_true;
        logic [PLA_TERMS-1:0][PLA_IN-1:0] and_comp;
        logic [PLA_OUTS-1:0][PLA_TERMS-1:0] or_sel;
        logic [PLA_OUTS-1:0] reg_out;
    } plt_pla_cfg_t;
endpackage

// file: design/plt_queue.sv
`timescale 1ns/1ps
module plt_queue (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [plt_pkg::DATA_W-1:0] push_data_i,
    input wire logic pop_i,
    output logic [plt_pkg::DATA_W-1:0] head_o,
    output logic empty_o,
    output logic full_o
);
    typedef struct packed {
        logic [plt_pkg::QUEUE_DEPTH-1:0][plt_pkg::DATA_W-1:0] mem;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] cnt;
    } plt_q_state_t;

    plt_q_state_t s_reg;
    plt_q_state_t s_next;
    logic do_push;
    logic do_pop;

    always_comb begin
        empty_o = (s_reg.cnt == 3'h0);
        full_o = (s_reg.cnt == 3'(plt_pkg::QUEUE_DEPTH));
        head_o = s_reg.mem[s_reg.rp];
        // Refused moves leave contents and pointers alone.
        do_push = push_i && !full_o;
        do_pop = pop_i && !empty_o;
        s_next = s_reg;
        if (do_push) begin
            s_next.mem[s_reg.wp] = push_data_i;
            s_next.wp = s_reg.wp + 2'h1;
        end
        if (do_pop) begin
            s_next.rp = s_reg.rp + 2'h1;
        end
        s_next.cnt = s_reg.cnt + 3'(do_push) - 3'(do_pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // plt_queue

// file: design/plt_tile.sv
`timescale 1ns/1ps
module plt_tile (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [plt_pkg::ADDR_W-1:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [plt_pkg::DATA_W-1:0] bus_wdata_i,
    output logic [plt_pkg::DATA_W-1:0] bus_rdata_o,
    input wire logic [plt_pkg::ROUTE_W-1:0] route_i,
    output logic [plt_pkg::ROUTE_W-1:0] route_o,
    input wire logic chain_cin_i,
    input wire logic chain_sin_i,
    input wire logic chain_cmp_i,
    output logic chain_cout_o,
    output logic chain_sout_o,
    output logic chain_cmp_o,
    input wire logic [plt_pkg::PLA_COUNT-1:0][plt_pkg::PLA_IN-1:0] pla_in_i,
    input wire plt_pkg::plt_pla_cfg_t [plt_pkg::PLA_COUNT-1:0] pla_cfg_i,
    output logic [plt_pkg::PLA_COUNT-1:0][plt_pkg::PLA_OUTS-1:0] pla_out_o
);
    typedef struct packed {
        logic [1:0][7:0] acc;
        logic [1:0][7:0] dat;
        logic [1:0][7:0] cmp_mask;
        logic [7:0] or_mask;
        logic [7:0] poly;
        logic [7:0] ctrl;
        logic [7:0] ctrl2;
        logic [2:0][7:0] osel;
        logic [plt_pkg::CFG_WORDS-1:0][plt_pkg::CFG_W-1:0] cfg_ram;
        logic carry;
        logic sout;
        logic [1:0] q_ovf;
        logic [1:0] q_unf;
        logic [7:0] rdata;
        logic [plt_pkg::ROUTE_W-1:0] route;
        logic chain_cout;
        logic chain_sout;
        logic chain_cmp;
    } plt_tile_state_t;

    plt_tile_state_t s_reg;
    plt_tile_state_t s_next;
    plt_pkg::plt_cfg_word_t cw;
    logic run;
    logic [2:0] msb;
    logic [7:0] wmask;
    logic [3:0] [7:0] srcs;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] addend;
    logic cin;
    logic cin_ext;
    logic [8:0] sum;
    logic [7:0] alu;
    logic cout;
    logic ovf;
    logic sin;
    logic fb;
    logic [7:0] sh;
    logic sh_out;
    logic [7:0] res;
    logic [1:0] eq;
    logic [1:0] lt;
    logic [1:0][7:0] cmp_a;
    logic [1:0][7:0] cmp_b;
    logic eq0_chained;
    logic [1:0] zero;
    logic [1:0] ones;
    logic [plt_pkg::COND_N-1:0] cond;
    logic [1:0] q_out_dir;
    logic [1:0] q_push;
    logic [1:0] q_pop;
    logic [1:0] q_bus_wr;
    logic [1:0] q_bus_rd;
    logic [1:0] q_dp;
    logic [1:0][7:0] q_head;
    logic [1:0] q_empty;
    logic [1:0] q_full;
    logic [7:0] capture;
    logic [1:0][1:0] q_tgt;
    logic [7:0] status;
    logic [3:0] osel_f;
    logic [2:0] cfg_idx;

    for (genvar g = 0; g < plt_pkg::PLA_COUNT; g++) begin : g_pla
        // Two arrays per tile; their outputs bypass the output flops
        // because combinational mode must stay combinational.
        plt_logic_array u_pla (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_i(pla_in_i[g]),
            .cfg_i(pla_cfg_i[g]),
            .out_o(pla_out_o[g])
        );
    end

    for (genvar q = 0; q < 2; q++) begin : g_queue
        plt_queue u_queue (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .push_i(q_push[q]),
            .push_data_i(q_out_dir[q] ? capture : bus_wdata_i),
            .pop_i(q_pop[q]),
            .head_o(q_head[q]),
            .empty_o(q_empty[q]),
            .full_o(q_full[q])
        );
    end

    always_comb begin
        // Configuration word picked by routed address every clock.
        cfg_idx = route_i[plt_pkg::ROUTE_ADDR_LSB +: 3];
        cw = plt_pkg::plt_cfg_word_t'(s_reg.cfg_ram[cfg_idx]);
        run = route_i[plt_pkg::ROUTE_RUN];
        msb = s_reg.ctrl[plt_pkg::CTRL_MSB_LSB +: 3];
        wmask = 8'(8'hFF >> (3'h7 - msb));
        srcs = {s_reg.dat[1], s_reg.dat[0], s_reg.acc[1], s_reg.acc[0]};
        opa = srcs[cw.src_a] & wmask;
        opb = srcs[cw.src_b] & wmask;
        cin_ext = s_reg.ctrl2[plt_pkg::CTRL2_CMP1_PAIR] ? chain_cin_i
                : route_i[plt_pkg::ROUTE_CIN];
        cin = cw.cin_reg ? s_reg.carry : cin_ext;

        // Increment and decrement reuse the adder with fixed operands.
        unique case (cw.func)
            plt_pkg::FN_INC: begin
                addend = 8'h00;
                cin = 1'b1;
            end
            plt_pkg::FN_DEC: addend = wmask;
            plt_pkg::FN_SUB: addend = ~opb & wmask;
            default: addend = opb;
        endcase
        if (cw.func == plt_pkg::FN_DEC) begin
            cin = 1'b0;
        end
        if (cw.func == plt_pkg::FN_PASS || cw.func == plt_pkg::FN_AND
                || cw.func == plt_pkg::FN_OR || cw.func == plt_pkg::FN_XOR) begin
            cin = 1'b0;
        end
        sum = {1'b0, opa} + {1'b0, addend} + {8'h00, cin};

        unique case (cw.func)
            plt_pkg::FN_PASS: alu = opa;
            plt_pkg::FN_AND: alu = opa & opb;
            plt_pkg::FN_OR: alu = opa | opb;
            plt_pkg::FN_XOR: alu = opa ^ opb;
            default: alu = sum[7:0] & wmask;
        endcase

        // Carry and overflow are taken at the programmed top bit.
        cout = sum[4'(msb) + 4'h1];
        ovf = (opa[msb] == addend[msb]) && (sum[msb] != opa[msb])
            && (cw.func inside {plt_pkg::FN_INC, plt_pkg::FN_DEC,
                                plt_pkg::FN_ADD, plt_pkg::FN_SUB});

        unique case (s_reg.ctrl[plt_pkg::CTRL_SIN_LSB +: 2])
            2'h0: sin = route_i[plt_pkg::ROUTE_SIN];
            2'h1: sin = chain_sin_i;
            2'h2: sin = s_reg.sout;
            default: sin = 1'b0;
        endcase

        fb = alu[msb] ^ sin;
        sh_out = 1'b0;
        unique case (cw.shift)
            plt_pkg::SH_LEFT: begin
                sh = {alu[6:0], sin};
                sh_out = alu[msb];
            end
            plt_pkg::SH_RIGHT: begin
                sh = (alu >> 1) & ~(8'h01 << msb) | ({7'h00, sin} << msb);
                sh_out = alu[0];
            end
            plt_pkg::SH_SWAP: sh = {alu[3:0], alu[7:4]};
            default: sh = alu;
        endcase
        if (cw.crc_en) begin
            // One Galois step; with serial input held low it runs as a
            // sequence generator.
            sh = {alu[6:0], 1'b0} ^ (fb ? s_reg.poly : 8'h00);
            sh_out = fb;
        end
        if (cw.or_mask_en) begin
            sh = sh | s_reg.or_mask;
        end
        res = sh & wmask;

        // Comparators with masks and two pairings each.
        cmp_a[0] = s_reg.acc[0];
        cmp_b[0] = s_reg.ctrl2[plt_pkg::CTRL2_CMP0_PAIR] ? s_reg.acc[1] : s_reg.dat[0];
        cmp_a[1] = s_reg.acc[1];
        cmp_b[1] = s_reg.ctrl2[plt_pkg::CTRL2_CMP1_PAIR] ? s_reg.dat[0] : s_reg.dat[1];
        for (int c = 0; c < 2; c++) begin
            eq[c] = (cmp_a[c] & s_reg.cmp_mask[c]) == (cmp_b[c] & s_reg.cmp_mask[c]);
            lt[c] = (cmp_a[c] & s_reg.cmp_mask[c]) < (cmp_b[c] & s_reg.cmp_mask[c]);
            zero[c] = (s_reg.acc[c] & wmask) == 8'h00;
            ones[c] = (s_reg.acc[c] & wmask) == wmask;
        end
        eq0_chained = eq[0] && (chain_cmp_i || !s_reg.ctrl[plt_pkg::CTRL_CHAIN_CMP]);

        cond = {1'b0, q_full[1], q_empty[1], q_full[0], q_empty[0],
                sh_out, cout, ovf, ones[1], zero[1], ones[0], zero[0],
                lt[1], eq[1], lt[0], eq0_chained};

        // Queue steering: direction picks which side fills and drains.
        q_out_dir[0] = s_reg.ctrl[plt_pkg::CTRL_Q0_OUT];
        q_out_dir[1] = s_reg.ctrl[plt_pkg::CTRL_Q1_OUT];
        q_dp = {run && cw.q1_xfer, run && cw.q0_xfer};
        q_bus_wr[0] = bus_wr_i && bus_addr_i == plt_pkg::ADDR_QUEUE0;
        q_bus_wr[1] = bus_wr_i && bus_addr_i == plt_pkg::ADDR_QUEUE1;
        q_bus_rd[0] = bus_rd_i && bus_addr_i == plt_pkg::ADDR_QUEUE0;
        q_bus_rd[1] = bus_rd_i && bus_addr_i == plt_pkg::ADDR_QUEUE1;
        unique case (s_reg.ctrl2[plt_pkg::CTRL2_CAP_LSB +: 2])
            2'h0: capture = s_reg.acc[0];
            2'h1: capture = s_reg.acc[1];
            default: capture = res;
        endcase
        q_tgt[0] = s_reg.ctrl2[plt_pkg::CTRL2_Q0_TGT_LSB +: 2];
        q_tgt[1] = s_reg.ctrl2[plt_pkg::CTRL2_Q1_TGT_LSB +: 2];
        for (int q = 0; q < 2; q++) begin
            q_push[q] = q_out_dir[q] ? q_dp[q] : q_bus_wr[q];
            q_pop[q] = q_out_dir[q] ? q_bus_rd[q] : q_dp[q];
        end

        status = {s_reg.q_unf[1], s_reg.q_ovf[1], s_reg.q_unf[0], s_reg.q_ovf[0],
                  q_full[1], q_empty[1], q_full[0], q_empty[0]};

        s_next = s_reg;

        // Datapath results go to accumulators only.
        if (run) begin
            if (cw.dest[0]) begin
                s_next.acc[0] = res;
            end
            if (cw.dest[1]) begin
                s_next.acc[1] = res;
            end
            s_next.carry = cout;
            s_next.sout = sh_out;
        end

        // Input queues load a working register; a second load of the
        // same cycle from queue one wins.
        for (int q = 0; q < 2; q++) begin
            if (q_dp[q] && !q_out_dir[q] && !q_empty[q]) begin
                unique case (q_tgt[q])
                    2'h0: s_next.acc[0] = q_head[q];
                    2'h1: s_next.acc[1] = q_head[q];
                    2'h2: s_next.dat[0] = q_head[q];
                    default: s_next.dat[1] = q_head[q];
                endcase
            end
        end

        // Bus writes override datapath updates in the same cycle.
        if (bus_wr_i) begin
            if (bus_addr_i[plt_pkg::CFG_SPACE_BIT]) begin
                if (bus_addr_i[0]) begin
                    s_next.cfg_ram[bus_addr_i[3:1]][15:8] = bus_wdata_i;
                end else begin
                    s_next.cfg_ram[bus_addr_i[3:1]][7:0] = bus_wdata_i;
                end
            end else begin
                unique case (bus_addr_i)
                    plt_pkg::ADDR_ACC0: s_next.acc[0] = bus_wdata_i;
                    plt_pkg::ADDR_ACC1: s_next.acc[1] = bus_wdata_i;
                    plt_pkg::ADDR_DAT0: s_next.dat[0] = bus_wdata_i;
                    plt_pkg::ADDR_DAT1: s_next.dat[1] = bus_wdata_i;
                    plt_pkg::ADDR_CMP_MASK0: s_next.cmp_mask[0] = bus_wdata_i;
                    plt_pkg::ADDR_CMP_MASK1: s_next.cmp_mask[1] = bus_wdata_i;
                    plt_pkg::ADDR_OR_MASK: s_next.or_mask = bus_wdata_i;
                    plt_pkg::ADDR_POLY: s_next.poly = bus_wdata_i;
                    plt_pkg::ADDR_CTRL: s_next.ctrl = bus_wdata_i;
                    plt_pkg::ADDR_OSEL0: s_next.osel[0] = bus_wdata_i;
                    plt_pkg::ADDR_OSEL1: s_next.osel[1] = bus_wdata_i;
                    plt_pkg::ADDR_OSEL2: s_next.osel[2] = bus_wdata_i;
                    plt_pkg::ADDR_CTRL2: s_next.ctrl2 = bus_wdata_i;
                    plt_pkg::ADDR_STATUS: begin
                        s_next.q_ovf[0] = s_reg.q_ovf[0] & ~bus_wdata_i[4];
                        s_next.q_unf[0] = s_reg.q_unf[0] & ~bus_wdata_i[5];
                        s_next.q_ovf[1] = s_reg.q_ovf[1] & ~bus_wdata_i[6];
                        s_next.q_unf[1] = s_reg.q_unf[1] & ~bus_wdata_i[7];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Refused bus moves are flagged; a new event beats a clear.
        for (int q = 0; q < 2; q++) begin
            if (q_bus_wr[q] && !q_out_dir[q] && q_full[q]) begin
                s_next.q_ovf[q] = 1'b1;
            end
            if (q_bus_rd[q] && q_out_dir[q] && q_empty[q]) begin
                s_next.q_unf[q] = 1'b1;
            end
        end

        // Read data is registered, so it appears one clock after the strobe.
        s_next.rdata = 8'h00;
        if (bus_rd_i) begin
            if (bus_addr_i[plt_pkg::CFG_SPACE_BIT]) begin
                s_next.rdata = bus_addr_i[0] ? s_reg.cfg_ram[bus_addr_i[3:1]][15:8]
                             : s_reg.cfg_ram[bus_addr_i[3:1]][7:0];
            end else begin
                unique case (bus_addr_i)
                    plt_pkg::ADDR_ACC0: s_next.rdata = s_reg.acc[0];
                    plt_pkg::ADDR_ACC1: s_next.rdata = s_reg.acc[1];
                    plt_pkg::ADDR_DAT0: s_next.rdata = s_reg.dat[0];
                    plt_pkg::ADDR_DAT1: s_next.rdata = s_reg.dat[1];
                    plt_pkg::ADDR_QUEUE0: s_next.rdata =
                        (q_out_dir[0] && !q_empty[0]) ? q_head[0] : 8'h00;
                    plt_pkg::ADDR_QUEUE1: s_next.rdata =
                        (q_out_dir[1] && !q_empty[1]) ? q_head[1] : 8'h00;
                    plt_pkg::ADDR_CMP_MASK0: s_next.rdata = s_reg.cmp_mask[0];
                    plt_pkg::ADDR_CMP_MASK1: s_next.rdata = s_reg.cmp_mask[1];
                    plt_pkg::ADDR_OR_MASK: s_next.rdata = s_reg.or_mask;
                    plt_pkg::ADDR_POLY: s_next.rdata = s_reg.poly;
                    plt_pkg::ADDR_CTRL: s_next.rdata = s_reg.ctrl;
                    plt_pkg::ADDR_STATUS: s_next.rdata = status;
                    plt_pkg::ADDR_OSEL0: s_next.rdata = s_reg.osel[0];
                    plt_pkg::ADDR_OSEL1: s_next.rdata = s_reg.osel[1];
                    plt_pkg::ADDR_OSEL2: s_next.rdata = s_reg.osel[2];
                    plt_pkg::ADDR_CTRL2: s_next.rdata = s_reg.ctrl2;
                    default: s_next.rdata = 8'h00;
                endcase
            end
        end

        // Six routed outputs, each picking one condition by a nibble.
        for (int o = 0; o < plt_pkg::ROUTE_W; o++) begin
            osel_f = s_reg.osel[o / 2][(o % 2) * 4 +: 4];
            s_next.route[o] = cond[osel_f];
        end

        // Chain outputs are registered, costing a clock per neighbour hop.
        s_next.chain_cout = cout;
        s_next.chain_sout = sh_out;
        s_next.chain_cmp = eq0_chained;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.cmp_mask <= {plt_pkg::RST_MASK, plt_pkg::RST_MASK};
            s_reg.or_mask <= plt_pkg::RST_BYTE;
            s_reg.ctrl <= plt_pkg::RST_CTRL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata_o = s_reg.rdata;
    assign route_o = s_reg.route;
    assign chain_cout_o = s_reg.chain_cout;
    assign chain_sout_o = s_reg.chain_sout;
    assign chain_cmp_o = s_reg.chain_cmp;
endmodule // plt_tile

// file: tb/plt_checker.sv
`timescale 1ns/1ps
module plt_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic [5:0] route_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rd_idle_a: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
        else $error("read data not idle");
    acc_write_a: assert property ($past(bus_wr_i) && bus_rd_i && !bus_wr_i &&
        bus_addr_i == 5'h00 && $past(bus_addr_i) == 5'h00
        |=> bus_rdata_o == $past(bus_wdata_i, 2)) else $error("accumulator readback wrong");
    dat_write_a: assert property ($past(bus_wr_i) && bus_rd_i && !bus_wr_i &&
        bus_addr_i == 5'h02 && $past(bus_addr_i) == 5'h02
        |=> bus_rdata_o == $past(bus_wdata_i, 2)) else $error("data register readback wrong");
    cfg_write_a: assert property ($past(bus_wr_i) && bus_rd_i && !bus_wr_i &&
        bus_addr_i[4] && $past(bus_addr_i) == bus_addr_i
        |=> bus_rdata_o == $past(bus_wdata_i, 2)) else $error("config readback wrong");
    ctrl_reset_a: assert property ($past(rst_i) && bus_rd_i && bus_addr_i == 5'h0A
        |=> bus_rdata_o == 8'h07) else $error("control reset wrong");
    status_reset_a: assert property ($past(rst_i) && bus_rd_i && bus_addr_i == 5'h0B
        |=> bus_rdata_o == 8'h05) else $error("status reset wrong");
    mask_reset_a: assert property ($past(rst_i) && bus_rd_i && bus_addr_i == 5'h06
        |=> bus_rdata_o == 8'hFF) else $error("mask reset wrong");
    route_reset_a: assert property ($past(rst_i) |-> route_o == 6'h00)
        else $error("route outputs not cleared");
    route_cond_a: assert property ($past(rst_i, 2) && !$past(rst_i) |-> route_o == 6'h3F)
        else $error("route conditions wrong after reset");
endmodule // plt_checker
bind plt_tile plt_checker chk (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .route_o(route_o));

// file: tb/plt_cpu_model.sv
`timescale 1ns/1ps
module plt_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [4:0] addr_o = 5'h00,
    output logic wr_o = 1'h0,
    output logic rd_o = 1'h0,
    output logic [7:0] wdata_o = 8'h00
);
    // Callers read and write registers and config words, but write only input queues and read only output queues.
    task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= r;
        addr_o <= a;
        wdata_o <= w ? d : ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        op(1'h0, 1'h1, a, 8'h00);
        op(1'h0, 1'h0, 5'h00, 8'h00);
        #1 d = rdata_i;
    endtask
endmodule // plt_cpu_model

// file: tb/test_programmable_logic_datapath_tile.sv
`timescale 1ns/1ps
module test_programmable_logic_datapath_tile;
    typedef struct {logic [7:0] lo; logic [7:0] hi; logic [7:0] exp;} plt_row_t;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [5:0] route_i = 6'h00;
    logic [7:0] rdata, seen, wdata;
    logic [4:0] addr;
    logic wr, rd;
    int fails = 0;
    int total_checks = 0;
    // Rows: config low byte, high byte, expected accumulator zero from 3C and 0F, no carry in.
    plt_row_t rows [11] = '{'{8'h40, 8'h04, 8'h3C}, '{8'h41, 8'h04, 8'h3D},
        '{8'h42, 8'h04, 8'h3B}, '{8'h43, 8'h04, 8'h4B}, '{8'h44, 8'h04, 8'h2C},
        '{8'h45, 8'h04, 8'h0C}, '{8'h46, 8'h04, 8'h3F}, '{8'h47, 8'h04, 8'h33},
        '{8'hC0, 8'h04, 8'h78}, '{8'h40, 8'h05, 8'h1E}, '{8'hC0, 8'h05, 8'hC3}};
    always #25 clk_i = ~clk_i;
    plt_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata));
    plt_tile dut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(addr), .bus_wr_i(wr),
        .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .route_i(route_i),
        .route_o(), .chain_cin_i(1'h0), .chain_sin_i(1'h0), .chain_cmp_i(1'h0),
        .chain_cout_o(), .chain_sout_o(), .chain_cmp_o(), .pla_in_i('0), .pla_cfg_i('0),
        .pla_out_o());
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] exp);
        cpu.rd(a, seen);
        cmp(what, exp, seen);
    endtask
    // The read rides the last reset edge so that it is taken on the first free edge.
    task automatic do_reset(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (14) @(posedge clk_i);
        cpu.op(1'h0, 1'h1, a, 8'h00);
        rst_i <= 1'h0;
        cpu.op(1'h0, 1'h0, 5'h00, 8'h00);
        #1 cmp("reset value", exp, rdata);
    endtask
    task automatic run(input logic [2:0] w, input int n);
        cpu.op(1'h0, 1'h0, 5'h00, 8'h00);
        route_i <= {3'h4, w};
        repeat (n) @(posedge clk_i);
        route_i <= 6'h00;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        do_reset(plt_pkg::ADDR_CTRL, plt_pkg::RST_CTRL);
        foreach (rows[i]) begin
            cpu.op(1'h1, 1'h0, plt_pkg::ADDR_ACC0, 8'h3C);
            cpu.op(1'h1, 1'h0, plt_pkg::ADDR_DAT0, 8'h0F);
            cpu.op(1'h1, 1'h0, 5'h10, rows[i].lo);
            cpu.op(1'h1, 1'h0, 5'h11, rows[i].hi);
            rchk("config high", 5'h11, rows[i].hi);
            run(3'h0, 1);
            rchk("alu result", plt_pkg::ADDR_ACC0, rows[i].exp);
        end
        rchk("data register", plt_pkg::ADDR_DAT0, 8'h0F);
        cpu.op(1'h1, 1'h0, plt_pkg::ADDR_ACC0, 8'h5A);
        rchk("acc write", plt_pkg::ADDR_ACC0, 8'h5A);
        cpu.op(1'h1, 1'h0, plt_pkg::ADDR_DAT0, 8'hA5);
        rchk("dat write", plt_pkg::ADDR_DAT0, 8'hA5);
        $display("test alu table done");
        for (int k = 0; k < 5; k++) cpu.op(1'h1, 1'h0, plt_pkg::ADDR_QUEUE0, 8'hA0 + 8'(k));
        rchk("status full", plt_pkg::ADDR_STATUS, 8'h16);
        cpu.op(1'h1, 1'h0, 5'h12, 8'h00);
        cpu.op(1'h1, 1'h0, 5'h13, 8'h40);
        run(3'h1, 5);
        rchk("queue load", plt_pkg::ADDR_ACC0, 8'hA3);
        rchk("status drained", plt_pkg::ADDR_STATUS, 8'h15);
        $display("test input queue done");
        cpu.op(1'h1, 1'h0, plt_pkg::ADDR_CTRL, 8'h17);
        cpu.op(1'h1, 1'h0, 5'h15, 8'h80);
        rchk("empty queue", plt_pkg::ADDR_QUEUE1, 8'h00);
        run(3'h2, 1);
        rchk("queue capture", plt_pkg::ADDR_QUEUE1, 8'hA3);
        rchk("status sticky", plt_pkg::ADDR_STATUS, 8'h95);
        $display("test output queue done");
        do_reset(plt_pkg::ADDR_STATUS, 8'h05);
        do_reset(plt_pkg::ADDR_CMP_MASK0, plt_pkg::RST_MASK);
        $display("test second reset done");
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        $display("[ERR] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule // test_programmable_logic_datapath_tile
